//--- design/cie_execute.sv
// Instruction execute unit: ALU, multiplier, transfers, skips and I/O access
`timescale 1ns/10ps
// Functional notes
// - Register sums, with or without carry, write result, set Z C N V H, one cycle.
// - Register differences, optional borrow, write result, set Z C N V H, one cycle.
// - Constant differences, optional borrow, write result, set Z C N V H, one cycle.
// - Word add/subtract immediate on register pair, two cycles, set Z C N V S.
// - AND, OR, XOR register and immediate forms store result, set Z N V only.
// - Clear-mask-bits ANDs destination with 0xFF minus mask, sets Z N V.
// - Mask-set ORs destination with constant, sets Z N V, one cycle.
// - Zero-minus check ANDs register with itself, sets Z N V, one cycle.
// - Products write 16 bits to pair 1:0, set only Z C, two cycles.
// - Fractional products shift left one before writing, set Z C, two cycles.
// - Relative transfers load PC plus k plus one; jump 2, invoke 3 cycles.
// - Indirect transfers load PC from Z; jump 2, invoke 3 cycles.
// - Direct transfers load absolute k; jump 3, invoke 4 cycles.
// - Compare-skip-equal skips next on equality, PC plus 2 or 3, no flags.
// - Compares compute difference without storing, set Z N V C H, one cycle.
// - Skip-on-register-bit-low skips when bit b is zero, no flags changed.
// - Single-bit I/O set, clear and skip allowed only up to address 0x1F.
// - Single-bit I/O set and clear touch only the addressed bit.
// - Dedicated I/O access covers 0x00-0x3F; data space uses address plus 0x20.
// - Extended I/O 0x60-0xFF reachable only through data-space access.
module cie_execute
  import cie_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic opValid,
  input wire cie_op_t opCode,
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic [7:0] pairHi,
  input wire logic [7:0] imm,
  input wire logic [2:0] bitSel,
  input wire logic [15:0] pcIn,
  input wire logic [15:0] zPtr,
  input wire logic [11:0] relOffset,
  input wire logic [15:0] absAddr,
  input wire logic nextTwoWord,
  input wire logic [7:0] ioAddrIn,
  input wire logic [7:0] ioRdData,
  output logic ready,
  output logic done,
  output logic resWr,
  output logic [7:0] resData,
  output logic wordWr,
  output logic [15:0] wordData,
  output logic prodWr,
  output logic [15:0] prodData,
  output logic pcLoad,
  output logic [15:0] pcNext,
  output logic stackPush,
  output logic [15:0] retAddr,
  output logic ioWr,
  output logic [7:0] ioAddr,
  output logic [7:0] ioWrMask,
  output logic [7:0] ioWrData,
  output logic ioErr,
  output logic [7:0] flags
);
  function automatic logic isBitIo(cie_op_t op);
    return op inside {OP_IO_SET, OP_IO_CLEAR, OP_SKIP_IO_HIGH, OP_SKIP_IO_LOW};
  endfunction
  function automatic logic isDedIo(cie_op_t op);
    return op inside {OP_IO_READ, OP_IO_WRITE};
  endfunction
  function automatic logic cInUsed(cie_op_t op);
    return op inside {OP_DIFF_BORROW, OP_CONST_DIFF_BORROW, OP_CMP_BORROW};
  endfunction

  cie_state_t stateQ;
  logic [2:0] remQ;
  logic doneQ, pResQ, pWordQ, pProdQ, pPushQ, pIoQ, pErrQ;
  logic [7:0] resDataQ, ioAddrQ, ioMaskQ, ioDataQ, flagsQ, flPendQ;
  logic [15:0] wordDataQ, prodDataQ, pcNextQ, retAddrQ;

  logic [7:0] bSel, res8, flD, mask1;
  logic cIn, hAdd, vAdd, hSub, vSub, skip, wrRes, wrWord, wrProd, push, ioW, ioE;
  logic [8:0] sum9, dif9;
  logic [15:0] w16, prod16, pcD, retD, pcRel;
  logic [17:0] prod18;
  logic [8:0] aX, bX;
  logic [2:0] cyc;
  logic accept, finish;

  assign ready = (stateQ == ST_IDLE);
  assign accept = opValid && ready;
  assign finish = (accept && cyc == CYC_ONE) || (stateQ == ST_WAIT && remQ == CYC_ONE);

  always_comb
  begin
    bSel = (opCode inside {OP_CONST_DIFF, OP_CONST_DIFF_BORROW, OP_CONJ_IMM, OP_DISJ_IMM,
      OP_MASK_SET, OP_CMP_IMM}) ? imm : opB;
    if (opCode == OP_MASK_CLEAR)
      bSel = BYTE_ALL - imm;
    if (opCode == OP_ZERO_MINUS_CHECK)
      bSel = opA;
    cIn = flagsQ[FL_C] && (opCode inside {OP_PLUS_CARRY, OP_DIFF_BORROW, OP_CONST_DIFF_BORROW,
      OP_CMP_BORROW});
    sum9 = {1'b0, opA} + {1'b0, bSel} + {8'h00, cIn};
    dif9 = {1'b0, opA} - {1'b0, bSel} - {8'h00, cIn};
    hAdd = (opA[3] & bSel[3]) | (bSel[3] & ~sum9[3]) | (~sum9[3] & opA[3]);
    vAdd = (opA[7] & bSel[7] & ~sum9[7]) | (~opA[7] & ~bSel[7] & sum9[7]);
    hSub = (~opA[3] & bSel[3]) | (bSel[3] & dif9[3]) | (dif9[3] & ~opA[3]);
    vSub = (opA[7] & ~bSel[7] & ~dif9[7]) | (~opA[7] & bSel[7] & dif9[7]);
    // Low byte is the named even register, high byte the next one
    w16 = (opCode == OP_WORD_PLUS_IMM) ? {pairHi, opA} + {10'h000, imm[5:0]}
                                       : {pairHi, opA} - {10'h000, imm[5:0]};
    aX = (opCode inside {OP_SPROD, OP_MPROD, OP_FSPROD, OP_FMPROD}) ? {opA[7], opA} : {1'b0, opA};
    bX = (opCode inside {OP_SPROD, OP_FSPROD}) ? {opB[7], opB} : {1'b0, opB};
    prod18 = 18'($signed(aX) * $signed(bX));
    prod16 = (opCode inside {OP_FUPROD, OP_FSPROD, OP_FMPROD}) ? {prod18[14:0], 1'b0}
                                                             : prod18[15:0];
    pcRel = pcIn + {{4{relOffset[11]}}, relOffset} + PC_STEP;
    mask1 = 8'h01 << bitSel;
    flD = flagsQ;
    res8 = opA;
    pcD = pcIn + PC_STEP;
    retD = pcIn + PC_STEP;
    cyc = CYC_ONE;
    skip = 1'b0;
    wrRes = 1'b0;
    wrWord = 1'b0;
    wrProd = 1'b0;
    push = 1'b0;
    ioW = 1'b0;
    ioE = 1'b0;
    unique case (opCode)
      OP_PLUS, OP_PLUS_CARRY:
      begin
        res8 = sum9[7:0];
        wrRes = 1'b1;
        flD[FL_H] = hAdd;
        flD[FL_V] = vAdd;
        flD[FL_N] = sum9[7];
        flD[FL_Z] = (sum9[7:0] == 8'h00);
        flD[FL_C] = sum9[8];
      end
      OP_DIFF, OP_DIFF_BORROW, OP_CONST_DIFF, OP_CONST_DIFF_BORROW, OP_CMP_REGS, OP_CMP_BORROW,
      OP_CMP_IMM:
      begin
        res8 = dif9[7:0];
        wrRes = !(opCode inside {OP_CMP_REGS, OP_CMP_BORROW, OP_CMP_IMM});
        flD[FL_H] = hSub;
        flD[FL_V] = vSub;
        flD[FL_N] = dif9[7];
        flD[FL_C] = dif9[8];
        // Borrow forms keep Z only while every byte so far was zero
        flD[FL_Z] = (dif9[7:0] == 8'h00) && (!cInUsed(opCode) || flagsQ[FL_Z]);
      end
      OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM:
      begin
        cyc = CYC_TWO;
        wrWord = 1'b1;
        flD[FL_N] = w16[15];
        flD[FL_Z] = (w16 == 16'h0000);
        if (opCode == OP_WORD_PLUS_IMM)
        begin
          flD[FL_V] = ~pairHi[7] & w16[15];
          flD[FL_C] = ~w16[15] & pairHi[7];
        end
        else
        begin
          flD[FL_V] = pairHi[7] & ~w16[15];
          flD[FL_C] = w16[15] & ~pairHi[7];
        end
        flD[FL_S] = flD[FL_N] ^ flD[FL_V];
      end
      OP_CONJ, OP_CONJ_IMM, OP_DISJ, OP_DISJ_IMM, OP_XOR_REGS, OP_MASK_SET, OP_MASK_CLEAR,
      OP_ZERO_MINUS_CHECK:
      begin
        if (opCode inside {OP_DISJ, OP_DISJ_IMM, OP_MASK_SET})
          res8 = opA | bSel;
        else if (opCode == OP_XOR_REGS)
          res8 = opA ^ bSel;
        else
          res8 = opA & bSel;
        wrRes = 1'b1;
        flD[FL_V] = 1'b0;
        flD[FL_N] = res8[7];
        flD[FL_Z] = (res8 == 8'h00);
      end
      OP_UPROD, OP_SPROD, OP_MPROD, OP_FUPROD, OP_FSPROD, OP_FMPROD:
      begin
        cyc = CYC_TWO;
        wrProd = 1'b1;
        flD[FL_C] = prod18[15];
        flD[FL_Z] = (prod16 == 16'h0000);
      end
      OP_REL_JUMP, OP_REL_INVOKE:
      begin
        pcD = pcRel;
        push = (opCode == OP_REL_INVOKE);
        cyc = push ? CYC_THREE : CYC_TWO;
      end
      OP_IND_JUMP, OP_IND_INVOKE:
      begin
        pcD = zPtr;
        push = (opCode == OP_IND_INVOKE);
        cyc = push ? CYC_THREE : CYC_TWO;
      end
      OP_DIR_JUMP, OP_DIR_INVOKE:
      begin
        pcD = absAddr;
        push = (opCode == OP_DIR_INVOKE);
        retD = pcIn + PC_SKIP_ONE;
        cyc = push ? CYC_FOUR : CYC_THREE;
      end
      OP_CMP_SKIP_EQ:
        skip = (opA == opB);
      OP_SKIP_REG_LOW:
        skip = !opA[bitSel];
      OP_SKIP_IO_HIGH, OP_SKIP_IO_LOW:
      begin
        ioE = (ioAddrIn > IO_BIT_MAX);
        skip = !ioE && (ioRdData[bitSel] == (opCode == OP_SKIP_IO_HIGH));
      end
      OP_IO_SET, OP_IO_CLEAR:
      begin
        cyc = CYC_TWO;
        ioE = (ioAddrIn > IO_BIT_MAX);
        ioW = !ioE;
      end
      OP_IO_READ, OP_IO_WRITE:
      begin
        ioE = (ioAddrIn > IO_DED_MAX);
        ioW = !ioE && (opCode == OP_IO_WRITE);
        wrRes = !ioE && (opCode == OP_IO_READ);
        res8 = ioRdData;
      end
      OP_DS_READ, OP_DS_WRITE:
      begin
        cyc = CYC_TWO;
        ioW = (opCode == OP_DS_WRITE);
        wrRes = (opCode == OP_DS_READ);
        res8 = ioRdData;
      end
    endcase
    if (skip)
    begin
      pcD = pcIn + (nextTwoWord ? PC_SKIP_TWO : PC_SKIP_ONE);
      cyc = nextTwoWord ? CYC_THREE : CYC_TWO;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stateQ <= ST_IDLE;
      remQ <= CYC_ONE;
    end
    else if (accept && cyc != CYC_ONE)
    begin
      stateQ <= ST_WAIT;
      remQ <= cyc - CYC_ONE;
    end
    else if (stateQ == ST_WAIT)
    begin
      remQ <= remQ - CYC_ONE;
      if (remQ == CYC_ONE)
        stateQ <= ST_IDLE;
    end
  end

  // Results are captured at acceptance and released on the final cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {pResQ, pWordQ, pProdQ, pPushQ, pIoQ, pErrQ} <= 6'h00;
      resDataQ <= 8'h00;
      wordDataQ <= 16'h0000;
      prodDataQ <= 16'h0000;
      pcNextQ <= 16'h0000;
      retAddrQ <= 16'h0000;
      ioAddrQ <= 8'h00;
      ioMaskQ <= 8'h00;
      ioDataQ <= 8'h00;
      flPendQ <= FLAGS_RST;
    end
    else if (accept)
    begin
      {pResQ, pWordQ, pProdQ, pPushQ, pIoQ, pErrQ} <= {wrRes, wrWord, wrProd, push, ioW, ioE};
      resDataQ <= res8;
      wordDataQ <= w16;
      prodDataQ <= prod16;
      pcNextQ <= pcD;
      retAddrQ <= retD;
      // Dedicated forms reach data space at the I/O number plus the offset
      ioAddrQ <= (isBitIo(opCode) || isDedIo(opCode)) ? ioAddrIn + IO_DS_OFFSET : ioAddrIn;
      // Per-bit enable keeps write-one-to-clear flags in the same byte intact
      ioMaskQ <= isBitIo(opCode) ? mask1 : BYTE_ALL;
      ioDataQ <= (opCode == OP_IO_SET) ? mask1 : (opCode == OP_IO_CLEAR) ? 8'h00 : opA;
      flPendQ <= flD;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      doneQ <= 1'b0;
      flagsQ <= FLAGS_RST;
    end
    else
    begin
      doneQ <= finish;
      if (finish)
        flagsQ <= accept ? flD : flPendQ;
    end
  end

  assign done = doneQ;
  assign resWr = doneQ && pResQ;
  assign wordWr = doneQ && pWordQ;
  assign prodWr = doneQ && pProdQ;
  assign stackPush = doneQ && pPushQ;
  assign ioWr = doneQ && pIoQ;
  assign ioErr = doneQ && pErrQ;
  assign pcLoad = doneQ;
  assign resData = resDataQ;
  assign wordData = wordDataQ;
  assign prodData = prodDataQ;
  assign pcNext = pcNextQ;
  assign retAddr = retAddrQ;
  assign ioAddr = ioAddrQ;
  assign ioWrMask = ioMaskQ;
  assign ioWrData = ioDataQ;
  assign flags = flagsQ;

  AST_SUM_ONE: assert property (@(posedge clk) disable iff (rst)
    accept && opCode == OP_PLUS |=> resWr && resData == 8'($past(opA) + $past(opB)))
    else $error("sum result wrong or late");
  AST_DIFF_CARRY: assert property (@(posedge clk) disable iff (rst)
    accept && opCode == OP_DIFF |=> flags[FL_C] == ($past(opA) < $past(opB)))
    else $error("difference carry wrong");
  AST_CONST_DIFF: assert property (@(posedge clk) disable iff (rst)
    accept && opCode == OP_CONST_DIFF |=> resWr && resData == 8'($past(opA) - $past(imm)))
    else $error("constant difference wrong");
  AST_WORD_TWO: assert property (@(posedge clk) disable iff (rst)
    accept && opCode == OP_WORD_PLUS_IMM |=> !done ##1 wordWr)
    else $error("word op not two cycles");
  AST_LOGIC_FLAGS: assert property (@(posedge clk) disable iff (rst)
    accept && opCode == OP_XOR_REGS |=> !flags[FL_V] && flags[FL_C] == $past(flags[FL_C]))
    else $error("logic op flags wrong");
  AST_PROD: assert property (@(posedge clk) disable iff (rst)
    accept && opCode == OP_UPROD |=> !prodWr ##1 prodWr && prodData == $past(16'(opA) * 16'(opB), 2))
    else $error("product wrong or mistimed");
  AST_DIR_JUMP: assert property (@(posedge clk) disable iff (rst)
    accept && opCode == OP_DIR_JUMP |=> !pcLoad [*2] ##1 pcLoad && pcNext == $past(absAddr, 3))
    else $error("direct jump wrong or mistimed");
  AST_IO_BIT_RANGE: assert property (@(posedge clk) disable iff (rst)
    accept && opCode == OP_IO_SET && ioAddrIn > IO_BIT_MAX |=> ##1 ioErr && !ioWr)
    else $error("bit op beyond range not refused");
  AST_IO_ONE_BIT: assert property (@(posedge clk) disable iff (rst)
    accept && opCode == OP_IO_CLEAR && ioAddrIn <= IO_BIT_MAX |=> ##1 ioWr && $onehot(ioWrMask))
    else $error("bit op touches more than one bit");
endmodule

//--- design/cie_pkg.sv
// Constants and types shared by the execute block
package cie_pkg;
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam logic [7:0] IO_BIT_MAX = 8'h1f;
  localparam logic [7:0] IO_DED_MAX = 8'h3f;
  localparam logic [7:0] IO_DS_OFFSET = 8'h20;
  localparam logic [7:0] BYTE_ALL = 8'hff;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
  localparam logic [15:0] PC_SKIP_TWO = 16'h0003;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;
  typedef enum logic [5:0] {
    OP_PLUS = 6'h00, OP_PLUS_CARRY = 6'h01, OP_DIFF = 6'h02, OP_DIFF_BORROW = 6'h03,
    OP_CONST_DIFF = 6'h04, OP_CONST_DIFF_BORROW = 6'h05, OP_WORD_PLUS_IMM = 6'h06,
    OP_WORD_MINUS_IMM = 6'h07, OP_CONJ = 6'h08, OP_CONJ_IMM = 6'h09, OP_DISJ = 6'h0a,
    OP_DISJ_IMM = 6'h0b, OP_XOR_REGS = 6'h0c, OP_MASK_SET = 6'h0d, OP_MASK_CLEAR = 6'h0e,
    OP_ZERO_MINUS_CHECK = 6'h0f, OP_UPROD = 6'h10, OP_SPROD = 6'h11, OP_MPROD = 6'h12,
    OP_FUPROD = 6'h13, OP_FSPROD = 6'h14, OP_FMPROD = 6'h15, OP_REL_JUMP = 6'h16,
    OP_IND_JUMP = 6'h17, OP_DIR_JUMP = 6'h18, OP_REL_INVOKE = 6'h19, OP_IND_INVOKE = 6'h1a,
    OP_DIR_INVOKE = 6'h1b, OP_CMP_SKIP_EQ = 6'h1c, OP_CMP_REGS = 6'h1d, OP_CMP_BORROW = 6'h1e,
    OP_CMP_IMM = 6'h1f, OP_SKIP_REG_LOW = 6'h20, OP_IO_SET = 6'h21, OP_IO_CLEAR = 6'h22,
    OP_SKIP_IO_HIGH = 6'h23, OP_SKIP_IO_LOW = 6'h24, OP_IO_READ = 6'h25, OP_IO_WRITE = 6'h26,
    OP_DS_READ = 6'h27, OP_DS_WRITE = 6'h28
  } cie_op_t;
  typedef enum logic {ST_IDLE = 1'b0, ST_WAIT = 1'b1} cie_state_t;
endpackage

//--- verification/cie_execute_bench.sv
// Self-checking bench for the execute block with an integer reference model
`timescale 1ns/10ps
module cie_execute_bench
  import cie_pkg::*;
;
  logic clk, rst, opValid, nextTwoWord;
  cie_op_t opCode;
  logic [7:0] opA, opB, pairHi, imm, ioAddrIn, ioRdData, resData, ioAddr, ioWrMask, ioWrData, flags;
  logic [2:0] bitSel;
  logic [11:0] relOffset;
  logic [15:0] pcIn, zPtr, absAddr, wordData, prodData, pcNext, retAddr;
  logic ready, done, resWr, wordWr, prodWr, pcLoad, stackPush, ioWr, ioErr;
  int n_mismatch = 0;
  int n_compared = 0;
  int tick = 0;
  int va, vb, vh, vi, vbit, vpc, vz, vrel, vabs, v2w, vaddr, seed;
  int mf, km, eRes, eWord, eProd, ePc, eCyc, eRet, eErr, eMi, eMv, eWr;
  int addrTab [8] = '{31, 32, 63, 64, 96, 255, 0, 128};
  cie_execute dut_u (.clk, .rst, .opValid, .opCode, .opA, .opB, .pairHi, .imm, .bitSel, .pcIn, .zPtr,
    .relOffset, .absAddr, .nextTwoWord, .ioAddrIn, .ioRdData, .ready, .done, .resWr, .resData, .wordWr,
    .wordData, .prodWr, .prodData, .pcLoad, .pcNext, .stackPush, .retAddr, .ioWr, .ioAddr, .ioWrMask,
    .ioWrData, .ioErr, .flags);
  cie_io_space part_u (.clk, .opCode, .ioAddrIn, .ioRdData, .ioWr, .ioAddr, .ioWrMask, .ioWrData);
  task automatic final_report();
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] act, input logic [15:0] exp);
    n_compared++;
    if (act !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  function automatic void setf(input int b, input bit v);
    mf = v ? (mf | (1 << b)) : (mf & ~(1 << b));
  endfunction
  // Byte add or subtract; S is not touched by these forms
  function automatic void arith(input int a, input int b, input int cin, input bit sub, input bit keepz);
    int r;
    r = sub ? a - b - cin : a + b + cin;
    setf(FL_H, sub ? ((a & 15) - (b & 15) - cin < 0) : ((a & 15) + (b & 15) + cin > 15));
    setf(FL_C, sub ? (r < 0) : (r > 255));
    r = r & 255;
    setf(FL_V, sub ? (a[7] != b[7] && r[7] != a[7]) : (a[7] == b[7] && r[7] != a[7]));
    setf(FL_N, r[7]);
    setf(FL_Z, (r == 0) && (!keepz || mf[FL_Z]));
    eRes = r;
  endfunction
  task automatic model(input int o);
    int s, x, y, p, w, sk, old;
    s = (o inside {4, 5, 9, 11, 13, 14, 31}) ? vi : vb;
    ePc = (vpc + 1) & 65535;
    eCyc = 1;
    eRes = -1;
    eWord = -1;
    eProd = -1;
    eRet = -1;
    eErr = 0;
    eMi = -1;
    eWr = 0;
    old = part_u.mem[(vaddr + 32) & 255];
    if (o inside {[0:5], [29:31]})
    begin
      arith(va, s, (o inside {1, 3, 5, 30}) ? mf[FL_C] : 0, !(o inside {0, 1}), o inside {3, 5, 30});
      if (o >= 29)
        eRes = -1;
    end
    else if (o inside {6, 7})
    begin
      w = vh * 256 + va;
      p = (o == 6) ? w + (vi & 63) : w - (vi & 63);
      setf(FL_C, p > 65535 || p < 0);
      p = p & 65535;
      eWord = p;
      setf(FL_N, p[15]);
      setf(FL_V, (o == 6) ? (!w[15] && p[15]) : (w[15] && !p[15]));
      setf(FL_S, mf[FL_N] ^ mf[FL_V]);
      setf(FL_Z, p == 0);
      eCyc = 2;
    end
    else if (o inside {[8:15]})
    begin
      case (o)
        8, 9: p = va & s;
        12: p = va ^ s;
        14: p = va & (255 - s);
        15: p = va;
        default: p = va | s;
      endcase
      eRes = p;
      setf(FL_N, p[7]);
      setf(FL_Z, p == 0);
      // Logic forms always leave overflow cleared
      setf(FL_V, 0);
    end
    else if (o inside {[16:21]})
    begin
      x = (o inside {17, 18, 20, 21} && va > 127) ? va - 256 : va;
      y = (o inside {17, 20} && vb > 127) ? vb - 256 : vb;
      p = (x * y) & 65535;
      setf(FL_C, p[15]);
      if (o >= 19)
        p = (p << 1) & 65535;
      setf(FL_Z, p == 0);
      eProd = p;
      eCyc = 2;
    end
    else if (o inside {[22:27]})
    begin
      case (o)
        22, 25: ePc = (vpc + (vrel > 2047 ? vrel - 4096 : vrel) + 1) & 65535;
        23, 26: ePc = vz;
        default: ePc = vabs;
      endcase
      eCyc = (o == 22 || o == 23) ? 2 : (o == 27) ? 4 : 3;
      if (o >= 25)
        eRet = (vpc + ((o == 27) ? 2 : 1)) & 65535;
    end
    else if (o inside {28, 32, 35, 36})
    begin
      eErr = (o >= 35 && vaddr > 31);
      sk = (o == 28) ? va == vb : (o == 32) ? !va[vbit] : (!eErr && old[vbit] == (o == 35));
      if (sk)
        ePc = (vpc + (v2w ? 3 : 2)) & 65535;
      if (sk)
        eCyc = v2w ? 3 : 2;
      if (eErr)
        eCyc = -1;
    end
    else
    begin
      eErr = (o inside {33, 34} && vaddr > 31) || (o inside {37, 38} && vaddr > 63);
      eMi = (o >= 39) ? vaddr : (vaddr + 32) & 255;
      eMv = part_u.mem[eMi];
      eWr = !eErr && (o inside {33, 34, 38, 40});
      case (o)
        33: eMv = eMv | (1 << vbit);
        34: eMv = eMv & ~(1 << vbit);
        37, 39: eRes = eErr ? -1 : eMv;
        default: eMv = va;
      endcase
      if (eErr)
        eMv = part_u.mem[eMi];
      eCyc = eErr ? -1 : (o inside {37, 38}) ? 1 : 2;
    end
  endtask
  task automatic run(input int o);
    int n;
    vh = $urandom % 256;
    vi = $urandom % 256;
    vbit = $urandom % 8;
    vpc = $urandom % 65536;
    vz = $urandom % 65536;
    vrel = $urandom % 4096;
    vabs = $urandom % 65536;
    v2w = $urandom % 2;
    model(o);
    @(posedge clk);
    opValid <= 1'b1;
    opCode <= cie_op_t'(o);
    opA <= 8'(va);
    opB <= 8'(vb);
    pairHi <= 8'(vh);
    imm <= 8'(vi);
    bitSel <= 3'(vbit);
    pcIn <= 16'(vpc);
    zPtr <= 16'(vz);
    relOffset <= 12'(vrel);
    absAddr <= 16'(vabs);
    nextTwoWord <= v2w[0];
    ioAddrIn <= 8'(vaddr);
    @(posedge clk);
    opValid <= 1'b0;
    // One-cycle work shows done right after the accept edge, so look there first
    #1;
    n = 1;
    if (eCyc > 1)
      cmp(16'(ready), 16'h0000);
    while (done !== 1'b1 && n < 6)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (eCyc > 0)
      cmp(16'(n), 16'(eCyc));
    cmp({8'h00, pcLoad, ready, ioErr, stackPush, resWr, wordWr, prodWr, ioWr},
      {8'h00, 1'b1, 1'b1, eErr[0], eRet >= 0, eRes >= 0, eWord >= 0, eProd >= 0, eWr[0]});
    if (eRes >= 0)
      cmp(16'(resData), 16'(eRes));
    if (eWord >= 0)
      cmp(wordData, 16'(eWord));
    if (eProd >= 0)
      cmp(prodData, 16'(eProd));
    if (eRet >= 0)
      cmp(retAddr, 16'(eRet));
    cmp(pcNext, 16'(ePc));
    cmp({8'h00, flags & 8'(km)}, {8'h00, 8'(mf & km)});
    @(posedge clk);
    #1;
    if (eMi >= 0)
      cmp(16'(part_u.mem[eMi]), 16'(eMv & 255));
    if (eWr)
      cmp({8'h00, ioAddr}, 16'(eMi));
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    tick <= tick + 1;
    if (tick == 20000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  initial
  begin
    seed = $urandom(80641);
    rst = 1'b1;
    {opValid, nextTwoWord, opA, opB, pairHi, imm, bitSel} = 37'h0;
    {pcIn, zPtr, relOffset, absAddr, ioAddrIn} = 68'h0;
    opCode = OP_PLUS;
    mf = 0;
    km = 255;
    vaddr = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    cmp({6'h00, flags, ready, done}, 16'h0002);
    // Edge operands first, then equal pairs and boundary addresses in rotation
    for (int r = 0; r < 24; r++)
    begin
      for (int o = 0; o <= 40; o++)
      begin
        va = (r == 0) ? 255 : $urandom % 256;
        vb = (r == 0) ? 1 : (r % 3 == 1) ? va : $urandom % 256;
        vaddr = (r % 4 == 3) ? $urandom % 256 : addrTab[r % 8];
        run(o);
      end
    end
    final_report();
  end
endmodule

//--- verification/cie_io_space.sv
// Behavioural I/O and data space on the far side of the execute block
`timescale 1ns/10ps
module cie_io_space
  import cie_pkg::*;
(
  input wire logic clk,
  input wire cie_op_t opCode,
  input wire logic [7:0] ioAddrIn,
  output logic [7:0] ioRdData,
  input wire logic ioWr,
  input wire logic [7:0] ioAddr,
  input wire logic [7:0] ioWrMask,
  input wire logic [7:0] ioWrData
);
  logic [7:0] mem [256];
  logic [7:0] rdIdx;
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      mem[i] = 8'(i * 37 + 11);
    end
  end
  // Dedicated forms see the offset view, data-space forms the raw address
  assign rdIdx = (opCode inside {OP_DS_READ, OP_DS_WRITE}) ? ioAddrIn : ioAddrIn + IO_DS_OFFSET;
  assign ioRdData = mem[rdIdx];
  // Masked merge, so write-one-to-clear neighbours survive a bit write
  always @(posedge clk)
  begin
    if (ioWr === 1'b1)
    begin
      mem[ioAddr] <= (mem[ioAddr] & ~ioWrMask) | (ioWrData & ioWrMask);
    end
  end
endmodule
